// file: drive_state_map.vh
// drive_state_map.vh: object indices, field positions, state codes and presets
// assumes: included by bare name by the drive state control files
`ifndef DRIVE_STATE_MAP_VH
`define DRIVE_STATE_MAP_VH

// ****************************************
// object dictionary indices and subindices
// ****************************************
`define IDX_ERROR_CODE 16'h603f
`define IDX_COMMAND 16'h6040
`define IDX_STATE_WORD 16'h6041
`define IDX_TARGET_SPEED 16'h6042
`define IDX_SPEED_DEMAND 16'h6043
`define IDX_SPEED_ACTUAL 16'h6044
`define IDX_SPEED_LIMITS 16'h6046
`define IDX_BOOT_INFO 16'h4042
`define SUB_ZERO 8'h00
`define SUB_ONE 8'h01
`define SUB_TWO 8'h02
`define SUB_THREE 8'h03
`define BOOT_ENTRIES 32'h0000_0003
`define LIMIT_ENTRIES 32'h0000_0002

// ****************************************
// command word fields
// ****************************************
`define CW_SWITCH_ON 0
`define CW_VOLTAGE 1
`define CW_QSTOP_N 2
`define CW_OPERATION 3
`define CW_MODE_LO 4
`define CW_MODE_HI 6
`define CW_FAULT_CLEAR 7
`define CW_HALT 8
`define CW_MODE_TOP 9

// ****************************************
// state word fields
// ****************************************
`define SW_VOLTAGE 4
`define SW_WARNING 7
`define SW_SYNC 8
`define SW_HOST 9
`define SW_GOAL 10
`define SW_LIMIT 11
`define SW_MODE_LO 12
`define SW_MODE_HI 13
`define SW_LOOP 15

// ****************************************
// power states and their state word pattern (bit6, bit5, bits3:0)
// ****************************************
`define ST_NOT_READY 3'h0
`define ST_INHIBIT 3'h1
`define ST_READY 3'h2
`define ST_SWITCHED_ON 3'h3
`define ST_OP_ENABLED 3'h4
`define ST_QUICK_STOP 3'h5
`define ST_FAULT_REACT 3'h6
`define ST_FAULT 3'h7
`define PAT_NOT_READY 6'h00
`define PAT_INHIBIT 6'h20
`define PAT_READY 6'h11
`define PAT_SWITCHED_ON 6'h13
`define PAT_OP_ENABLED 6'h17
`define PAT_QUICK_STOP 6'h07
`define PAT_FAULT_REACT 6'h0f
`define PAT_FAULT 6'h08

// ****************************************
// operating modes
// ****************************************
`define MODE_PROFILE_POS 8'h01
`define MODE_VELOCITY 8'h02
`define MODE_PROFILE_VEL 8'h03
`define MODE_PROFILE_TRQ 8'h04
`define MODE_INTERP_POS 8'h07

// ****************************************
// reset values
// ****************************************
`define RST_COMMAND 16'h0000
`define RST_ERROR_CODE 16'h0000
`define RST_STATE_WORD 16'h0000
`define RST_TARGET_SPEED 16'h00c8
`define RST_SPEED 16'h0000
`define RST_MIN_AMOUNT 32'h0000_0000
`define RST_MAX_AMOUNT 32'h0000_7530

`endif

// file: speed_limiter.v
// speed_limiter.v: clamps a signed target speed to a min/max magnitude window
// assumes: limits and target come from logic on the same clock
`timescale 1ns/1ps
`include "drive_state_map.vh"

module speed_limiter #(
  parameter W = 16
) (
  // clock and reset
  input wire mclk,
  input wire reset,
  // request and window
  input wire [W-1:0] target,
  input wire [31:0] min_amount,
  input wire [31:0] max_amount,
  // clamped result
  output reg [W-1:0] clamped_ff,
  output reg limit_hit_ff
);

  // ****************************************
  // magnitude compare
  // ****************************************
  wire neg = target[W-1];
  wire [W-1:0] neg_target = (~target) + {{(W-1){1'b0}}, 1'b1};
  wire [31:0] mag = {{(32-W){1'b0}}, neg ? neg_target : target};
  wire below = mag < min_amount;
  wire above = mag > max_amount;
  wire [31:0] lim_mag = below ? min_amount : max_amount;
  wire [W-1:0] lim_w = lim_mag[W-1:0];
  wire [W-1:0] lim_signed = neg ? ((~lim_w) + {{(W-1){1'b0}}, 1'b1}) : lim_w;
  reg [W-1:0] nxt_clamped;

  always @* begin
    nxt_clamped = target;
    if (below || above) begin
      nxt_clamped = lim_signed;
    end
  end

  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      clamped_ff <= `RST_SPEED;
      limit_hit_ff <= 1'b0;
    end else begin
      clamped_ff <= nxt_clamped;
      limit_hit_ff <= below | above;
    end
  end

endmodule // speed_limiter

// file: drive_state_control_status.v
// drive_state_control_status.v: command word, power state machine, state word,
// last error code, velocity words and boot information objects
// assumes: all inputs come from logic on mclk; the host issues one object
// request at a time and waits for its acknowledge
`timescale 1ns/1ps
`include "drive_state_map.vh"

module drive_state_control_status #(
  parameter [15:0] BOOT_MAJOR = 16'h0000, // arbitrary value
  parameter [15:0] BOOT_MINOR = 16'h0000, // arbitrary value
  parameter [31:0] BOOT_BUSES = 32'h0000_0000, // arbitrary value
  parameter [31:0] BOOT_HW_GROUP = 32'h0000_0000 // arbitrary value
) (
  // clock and reset
  input wire mclk,
  input wire reset,
  // object access from the fieldbus host
  input wire obj_req,
  input wire obj_we,
  input wire [15:0] obj_index,
  input wire [7:0] obj_sub,
  input wire [31:0] obj_wdata,
  output reg obj_ack_ff,
  output reg obj_err_ff,
  output reg [31:0] obj_rdata_ff,
  // drive side events and conditions
  input wire [7:0] op_mode,
  input wire error_event,
  input wire [15:0] error_code_in,
  input wire error_persists,
  input wire warning_event,
  input wire react_done,
  input wire quick_stop_done,
  input wire power_applied,
  input wire bus_synced,
  input wire special_mode_on,
  input wire goal_reached,
  input wire closed_loop_on,
  input wire [1:0] mode_status_bits,
  input wire [15:0] speed_measured,
  // drive side commands and state
  output reg [2:0] power_state_ff,
  output reg [15:0] state_word_ff,
  output reg halt_ff,
  output reg [3:0] mode_specific_bits_ff,
  output reg [7:0] mode_tag_ff,
  output reg [15:0] speed_demand_ff
);

  // ****************************************
  // storage
  // ****************************************
  reg [15:0] command_ff;
  reg [15:0] error_code_ff;
  reg [15:0] target_ff;
  reg [15:0] speed_actual_ff;
  reg [31:0] min_amount_ff;
  reg [31:0] max_amount_ff;
  reg fault_clear_prev_ff;
  reg warning_ff;
  reg [2:0] nxt_state;
  reg [5:0] pattern;
  reg [31:0] nxt_rdata;
  reg nxt_err;
  wire [15:0] clamped;
  wire limit_hit;

  wire switch_on_bit = command_ff[`CW_SWITCH_ON];
  wire enable_voltage_bit = command_ff[`CW_VOLTAGE];
  wire quick_stop_n = command_ff[`CW_QSTOP_N];
  wire enable_operation_bit = command_ff[`CW_OPERATION];
  wire fault_clear_request = command_ff[`CW_FAULT_CLEAR];
  wire fault_clear_edge = fault_clear_request & ~fault_clear_prev_ff;
  wire clear_ok = fault_clear_edge & ~error_persists;

  // decoded commands
  wire cmd_shutdown = enable_voltage_bit & quick_stop_n & ~switch_on_bit;
  wire cmd_switch_on = enable_voltage_bit & quick_stop_n & switch_on_bit &
                       ~enable_operation_bit;
  wire cmd_enable_op = enable_voltage_bit & quick_stop_n & switch_on_bit &
                       enable_operation_bit;
  wire cmd_no_voltage = ~enable_voltage_bit;
  wire cmd_quick_stop = enable_voltage_bit & ~quick_stop_n;

  wire halt_mode = (op_mode == `MODE_PROFILE_POS) || (op_mode == `MODE_VELOCITY) ||
                   (op_mode == `MODE_PROFILE_VEL) || (op_mode == `MODE_PROFILE_TRQ) ||
                   (op_mode == `MODE_INTERP_POS);

  wire wr = obj_req & obj_we;
  wire wr_command = wr && obj_index == `IDX_COMMAND && obj_sub == `SUB_ZERO;
  wire wr_target = wr && obj_index == `IDX_TARGET_SPEED && obj_sub == `SUB_ZERO;
  wire wr_min = wr && obj_index == `IDX_SPEED_LIMITS && obj_sub == `SUB_ONE;
  wire wr_max = wr && obj_index == `IDX_SPEED_LIMITS && obj_sub == `SUB_TWO;

  // ****************************************
  // power state machine
  // ****************************************
  always @* begin
    nxt_state = power_state_ff;
    if (error_event && power_state_ff != `ST_FAULT_REACT &&
        power_state_ff != `ST_FAULT) begin
      nxt_state = `ST_FAULT_REACT;
    end else begin
      case (power_state_ff)
        `ST_NOT_READY: begin
          nxt_state = `ST_INHIBIT;
        end
        `ST_INHIBIT: begin
          if (cmd_shutdown) begin
            nxt_state = `ST_READY;
          end
        end
        `ST_READY: begin
          if (cmd_no_voltage || cmd_quick_stop) begin
            nxt_state = `ST_INHIBIT;
          end else if (cmd_switch_on) begin
            nxt_state = `ST_SWITCHED_ON;
          end
        end
        `ST_SWITCHED_ON: begin
          if (cmd_no_voltage || cmd_quick_stop) begin
            nxt_state = `ST_INHIBIT;
          end else if (cmd_shutdown) begin
            nxt_state = `ST_READY;
          end else if (cmd_enable_op) begin
            nxt_state = `ST_OP_ENABLED;
          end
        end
        `ST_OP_ENABLED: begin
          if (cmd_no_voltage) begin
            nxt_state = `ST_INHIBIT;
          end else if (cmd_quick_stop) begin
            nxt_state = `ST_QUICK_STOP;
          end else if (cmd_shutdown) begin
            nxt_state = `ST_READY;
          end else if (cmd_switch_on) begin
            nxt_state = `ST_SWITCHED_ON;
          end
        end
        `ST_QUICK_STOP: begin
          if (cmd_no_voltage || quick_stop_done) begin
            nxt_state = `ST_INHIBIT;
          end else if (cmd_enable_op) begin
            nxt_state = `ST_OP_ENABLED;
          end
        end
        `ST_FAULT_REACT: begin
          if (react_done) begin
            nxt_state = `ST_FAULT;
          end
        end
        `ST_FAULT: begin
          if (clear_ok && !error_event) begin
            nxt_state = `ST_INHIBIT;
          end
        end
        default: begin
          nxt_state = `ST_NOT_READY;
        end
      endcase
    end
  end

  // ****************************************
  // state word pattern
  // ****************************************
  always @* begin
    case (power_state_ff)
      `ST_NOT_READY: pattern = `PAT_NOT_READY;
      `ST_INHIBIT: pattern = `PAT_INHIBIT;
      `ST_READY: pattern = `PAT_READY;
      `ST_SWITCHED_ON: pattern = `PAT_SWITCHED_ON;
      `ST_OP_ENABLED: pattern = `PAT_OP_ENABLED;
      `ST_QUICK_STOP: pattern = `PAT_QUICK_STOP;
      `ST_FAULT_REACT: pattern = `PAT_FAULT_REACT;
      `ST_FAULT: pattern = `PAT_FAULT;
      default: pattern = `PAT_NOT_READY;
    endcase
  end

  wire [15:0] nxt_state_word = {
    power_state_ff == `ST_OP_ENABLED && closed_loop_on,
    1'b0,
    mode_status_bits,
    limit_hit,
    goal_reached,
    ~special_mode_on,
    bus_synced,
    warning_ff,
    pattern[5:4],
    power_applied,
    pattern[3:0]
  };

  // ****************************************
  // object read mux
  // ****************************************
  always @* begin
    nxt_rdata = 32'h0000_0000;
    nxt_err = 1'b0;
    if (obj_index == `IDX_BOOT_INFO) begin
      case (obj_sub)
        `SUB_ZERO: nxt_rdata = `BOOT_ENTRIES;
        `SUB_ONE: nxt_rdata = {BOOT_MAJOR, BOOT_MINOR};
        `SUB_TWO: nxt_rdata = BOOT_BUSES;
        `SUB_THREE: nxt_rdata = BOOT_HW_GROUP;
        default: nxt_err = 1'b1;
      endcase
      nxt_err = nxt_err | obj_we;
    end else if (obj_index == `IDX_SPEED_LIMITS) begin
      case (obj_sub)
        `SUB_ZERO: nxt_err = obj_we;
        `SUB_ONE: nxt_rdata = min_amount_ff;
        `SUB_TWO: nxt_rdata = max_amount_ff;
        default: nxt_err = 1'b1;
      endcase
      if (obj_sub == `SUB_ZERO) begin
        nxt_rdata = `LIMIT_ENTRIES;
      end
    end else if (obj_sub != `SUB_ZERO) begin
      nxt_err = 1'b1;
    end else begin
      case (obj_index)
        `IDX_ERROR_CODE: begin
          nxt_rdata = {16'h0000, error_code_ff};
          nxt_err = obj_we;
        end
        `IDX_COMMAND: nxt_rdata = {16'h0000, command_ff};
        `IDX_STATE_WORD: begin
          nxt_rdata = {16'h0000, state_word_ff};
          nxt_err = obj_we;
        end
        `IDX_TARGET_SPEED: nxt_rdata = {16'h0000, target_ff};
        `IDX_SPEED_DEMAND: begin
          nxt_rdata = {16'h0000, speed_demand_ff};
          nxt_err = obj_we;
        end
        `IDX_SPEED_ACTUAL: begin
          nxt_rdata = {16'h0000, speed_actual_ff};
          nxt_err = obj_we;
        end
        default: nxt_err = 1'b1;
      endcase
    end
  end

  // ****************************************
  // speed clamp
  // ****************************************
  speed_limiter #(
    .W(16)
  ) u_limiter (
    .mclk(mclk),
    .reset(reset),
    .target(target_ff),
    .min_amount(min_amount_ff),
    .max_amount(max_amount_ff),
    .clamped_ff(clamped),
    .limit_hit_ff(limit_hit)
  );

  // ****************************************
  // registers
  // ****************************************
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      command_ff <= `RST_COMMAND;
      error_code_ff <= `RST_ERROR_CODE;
      target_ff <= `RST_TARGET_SPEED;
      speed_actual_ff <= `RST_SPEED;
      min_amount_ff <= `RST_MIN_AMOUNT;
      max_amount_ff <= `RST_MAX_AMOUNT;
      fault_clear_prev_ff <= 1'b0;
      warning_ff <= 1'b0;
      power_state_ff <= `ST_NOT_READY;
      state_word_ff <= `RST_STATE_WORD;
      halt_ff <= 1'b0;
      mode_specific_bits_ff <= 4'h0;
      mode_tag_ff <= 8'h00;
      speed_demand_ff <= `RST_SPEED;
      obj_ack_ff <= 1'b0;
      obj_err_ff <= 1'b0;
      obj_rdata_ff <= 32'h0000_0000;
    end else begin
      if (wr_command) begin
        command_ff <= obj_wdata[15:0];
      end
      if (wr_target) begin
        target_ff <= obj_wdata[15:0];
      end
      if (wr_min) begin
        min_amount_ff <= obj_wdata;
      end
      if (wr_max) begin
        max_amount_ff <= obj_wdata;
      end
      fault_clear_prev_ff <= fault_clear_request;
      // a new error in the clearing cycle wins over the clear
      if (error_event) begin
        error_code_ff <= error_code_in;
      end else if (clear_ok) begin
        error_code_ff <= `RST_ERROR_CODE;
      end
      if (warning_event) begin
        warning_ff <= 1'b1;
      end else if (clear_ok) begin
        warning_ff <= 1'b0;
      end
      speed_actual_ff <= speed_measured;
      power_state_ff <= nxt_state;
      state_word_ff <= nxt_state_word;
      halt_ff <= command_ff[`CW_HALT] & halt_mode;
      mode_specific_bits_ff <= {command_ff[`CW_MODE_TOP],
                                command_ff[`CW_MODE_HI:`CW_MODE_LO]};
      mode_tag_ff <= op_mode;
      if (power_state_ff == `ST_OP_ENABLED && op_mode == `MODE_VELOCITY &&
          !command_ff[`CW_HALT]) begin
        speed_demand_ff <= clamped;
      end else begin
        speed_demand_ff <= `RST_SPEED;
      end
      obj_ack_ff <= obj_req;
      obj_err_ff <= obj_req & nxt_err;
      if (obj_req) begin
        obj_rdata_ff <= nxt_rdata;
      end
    end
  end

endmodule // drive_state_control_status

// file: drive_state_checker.sv
// drive_state_checker.sv: concurrent checks on the drive state control block ports
// assumes: bound into drive_state_control_status, one clock mclk, async reset
`timescale 1ns/1ps
`include "drive_state_map.vh"

module drive_state_checker (
  // clock and reset
  input wire mclk,
  input wire reset,
  // object bus
  input wire obj_req,
  input wire obj_we,
  input wire [15:0] obj_index,
  input wire [7:0] obj_sub,
  input wire obj_ack_ff,
  input wire obj_err_ff,
  input wire [31:0] obj_rdata_ff,
  // drive side
  input wire [7:0] op_mode,
  input wire error_event,
  input wire react_done,
  input wire power_applied,
  input wire bus_synced,
  input wire special_mode_on,
  input wire closed_loop_on,
  input wire [2:0] power_state_ff,
  input wire [15:0] state_word_ff,
  input wire halt_ff,
  input wire [15:0] speed_demand_ff
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  function [5:0] pat_of(input [2:0] s);
    begin
      case (s)
        `ST_NOT_READY: pat_of = `PAT_NOT_READY;
        `ST_INHIBIT: pat_of = `PAT_INHIBIT;
        `ST_READY: pat_of = `PAT_READY;
        `ST_SWITCHED_ON: pat_of = `PAT_SWITCHED_ON;
        `ST_OP_ENABLED: pat_of = `PAT_OP_ENABLED;
        `ST_QUICK_STOP: pat_of = `PAT_QUICK_STOP;
        `ST_FAULT_REACT: pat_of = `PAT_FAULT_REACT;
        default: pat_of = `PAT_FAULT;
      endcase
    end
  endfunction

  // ****************************************
  // single-cycle trigger conditions
  // ****************************************
  sequence ro_write;
    obj_req && obj_we && (obj_index inside {`IDX_ERROR_CODE, `IDX_STATE_WORD,
      `IDX_SPEED_DEMAND, `IDX_SPEED_ACTUAL, `IDX_BOOT_INFO});
  endsequence
  sequence word_read;
    obj_req && !obj_we && obj_sub == `SUB_ZERO && (obj_index inside {`IDX_ERROR_CODE,
      `IDX_COMMAND, `IDX_STATE_WORD, `IDX_TARGET_SPEED, `IDX_SPEED_DEMAND});
  endsequence
  sequence new_error;
    error_event && power_state_ff != `ST_FAULT_REACT && power_state_ff != `ST_FAULT;
  endsequence
  sequence reaction_over;
    power_state_ff == `ST_FAULT_REACT && react_done;
  endsequence

  // ****************************************
  // assertions
  // ****************************************
  AST_RO_WRITE: assert property (ro_write |=> obj_ack_ff && obj_err_ff)
    else $error("read-only write not refused");
  AST_CMD_WRITE: assert property (obj_req && obj_we && obj_index == `IDX_COMMAND
    && obj_sub == `SUB_ZERO |=> obj_ack_ff && !obj_err_ff)
    else $error("command write not accepted");
  AST_WORD_READ: assert property (word_read |=> obj_ack_ff && !obj_err_ff
    && obj_rdata_ff[31:16] == 16'h0000)
    else $error("word read not zero extended");
  AST_HALT_MODE: assert property (halt_ff |-> $past(op_mode) inside {`MODE_PROFILE_POS,
    `MODE_VELOCITY, `MODE_PROFILE_VEL, `MODE_PROFILE_TRQ, `MODE_INTERP_POS})
    else $error("halt outside halt capable mode");
  AST_LEVELS: assert property (!$past(reset) |->
    state_word_ff[`SW_VOLTAGE] == $past(power_applied) && state_word_ff[`SW_SYNC] ==
    $past(bus_synced) && state_word_ff[`SW_HOST] == !$past(special_mode_on))
    else $error("state word level bits wrong");
  AST_CLOSED_LOOP: assert property (state_word_ff[`SW_LOOP] |->
    $past(power_state_ff) == `ST_OP_ENABLED && $past(closed_loop_on))
    else $error("closed loop flag outside operation enabled");
  AST_PATTERN: assert property (!$past(reset) |->
    {state_word_ff[6:5], state_word_ff[3:0]} == pat_of($past(power_state_ff)))
    else $error("state pattern does not match state");
  AST_ERROR_REACT: assert property (new_error |=> power_state_ff == `ST_FAULT_REACT)
    else $error("error did not start fault reaction");
  AST_FAULT_ENTRY: assert property (reaction_over |=> power_state_ff == `ST_FAULT)
    else $error("fault state not entered");
  AST_DEMAND_IDLE: assert property (($past(power_state_ff) != `ST_OP_ENABLED &&
    $past(power_state_ff, 2) != `ST_OP_ENABLED) |-> speed_demand_ff == 16'h0000)
    else $error("speed demand outside operation enabled");
endmodule // drive_state_checker

bind drive_state_control_status drive_state_checker chk (.*);

// file: fieldbus_host_model.sv
// fieldbus_host_model.sv: host side of the object bus, one request at a time
// assumes: requests are one-cycle pulses answered on the same edge that takes them
`timescale 1ns/1ps

module fieldbus_host_model (
  // clock
  input wire mclk,
  // request
  output reg obj_req,
  output reg obj_we,
  output reg [15:0] obj_index,
  output reg [7:0] obj_sub,
  output reg [31:0] obj_wdata,
  // answer
  input wire obj_ack_ff,
  input wire obj_err_ff,
  input wire [31:0] obj_rdata_ff
);
  initial begin
    obj_req = 1'b0;
    obj_we = 1'b0;
    obj_index = 16'h0000;
    obj_sub = 8'h00;
    obj_wdata = 32'h0000_0000;
  end

  // released index, sub and write data are inverted so a stale value is never mistaken for a request
  task xfer(input we, input [15:0] idx, input [7:0] sub, input [31:0] wd,
    output [31:0] rd, output ack, output err);
    begin
      @(posedge mclk);
      obj_req <= 1'b1;
      obj_we <= we;
      obj_index <= idx;
      obj_sub <= sub;
      obj_wdata <= wd;
      @(posedge mclk);
      obj_req <= 1'b0;
      obj_index <= ~idx;
      obj_sub <= ~sub;
      obj_wdata <= ~wd;
      #1;
      rd = obj_rdata_ff;
      ack = obj_ack_ff;
      err = obj_err_ff;
    end
  endtask
endmodule // fieldbus_host_model

// file: drive_state_control_status_bench.sv
// drive_state_control_status_bench.sv: self-checking bench for the drive state block
// assumes: host model drives the object bus; checker is bound to the design
`timescale 1ns/1ps
`include "drive_state_map.vh"

module drive_state_control_status_bench;
  reg mclk, reset, error_event, error_persists, warning_event, react_done, quick_stop_done;
  reg power_applied, bus_synced, special_mode_on, goal_reached, closed_loop_on, ack, err, warn;
  reg [7:0] op_mode;
  reg [15:0] error_code_in, speed_measured, v, lo, hi;
  reg [1:0] mode_status_bits;
  reg [31:0] rd;
  reg [16:0] c;
  wire obj_req, obj_we, obj_ack_ff, obj_err_ff, halt_ff;
  wire [15:0] obj_index, state_word_ff, speed_demand_ff;
  wire [7:0] obj_sub, mode_tag_ff;
  wire [31:0] obj_wdata, obj_rdata_ff;
  wire [2:0] power_state_ff;
  wire [3:0] mode_specific_bits_ff;
  integer num_errors, num_checks, i;

  drive_state_control_status #(.BOOT_MAJOR(16'h0005), .BOOT_MINOR(16'h0009),
    .BOOT_BUSES(32'h0000_0011), .BOOT_HW_GROUP(32'h0000_0022)) dut (.*); // arbitrary values
  fieldbus_host_model host (.*);

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // ****************************************
  // helpers
  // ****************************************
  task cmp(input [31:0] got, input [31:0] exp, input string what);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("wrong value at %0t: %0s got %h expected %h", $time, what, got, exp);
      end
    end
  endtask

  task acc(input we, input [15:0] idx, input [7:0] sub, input [31:0] wd, input exp_err);
    begin
      host.xfer(we, idx, sub, wd, rd, ack, err);
      cmp({ack, err}, {1'b1, exp_err}, "answer");
    end
  endtask

  task rdchk(input [15:0] idx, input [7:0] sub, input [31:0] exp);
    begin
      acc(1'b0, idx, sub, 32'h0000_0000, 1'b0);
      cmp(rd, exp, "read data");
    end
  endtask

  function [15:0] exp_word(input [2:0] s);
    reg [5:0] p;
    begin
      case (s)
        `ST_INHIBIT: p = `PAT_INHIBIT;
        `ST_READY: p = `PAT_READY;
        `ST_SWITCHED_ON: p = `PAT_SWITCHED_ON;
        `ST_OP_ENABLED: p = `PAT_OP_ENABLED;
        `ST_QUICK_STOP: p = `PAT_QUICK_STOP;
        default: p = `PAT_FAULT;
      endcase
      exp_word = {closed_loop_on && s == `ST_OP_ENABLED, 1'b0, mode_status_bits, 1'b0,
        goal_reached, !special_mode_on, bus_synced, warn, p[5:4], power_applied, p[3:0]};
    end
  endfunction

  function [16:0] clamp(input [15:0] t);
    reg [15:0] m;
    begin
      m = t[15] ? -t : t;
      if (m < lo) clamp = {1'b1, t[15] ? -lo : lo};
      else if (m > hi) clamp = {1'b1, t[15] ? -hi : hi};
      else clamp = {1'b0, t};
    end
  endfunction

  task step(input [15:0] cmd, input [2:0] st);
    begin
      @(posedge mclk);
      {bus_synced, special_mode_on, goal_reached} <= $urandom;
      {closed_loop_on, mode_status_bits, power_applied} <= $urandom;
      acc(1'b1, `IDX_COMMAND, `SUB_ZERO, {16'h0000, cmd}, 1'b0);
      @(posedge mclk);
      #1;
      cmp(power_state_ff, st, "state");
      acc(1'b0, `IDX_STATE_WORD, `SUB_ZERO, 32'h0000_0000, 1'b0);
      cmp(rd, exp_word(st), "state word");
    end
  endtask

  task stop_test;
    begin
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
        $display("== PASSED ==");
      end else begin
        $display("== FAILED ==");
      end
      $finish;
    end
  endtask

  initial begin
    #400_000;
    num_errors = num_errors + 1;
    stop_test;
  end

  // ****************************************
  // tests
  // ****************************************
  initial begin
    {error_event, error_persists, warning_event, react_done, quick_stop_done} = 5'h00;
    {power_applied, bus_synced, special_mode_on, goal_reached, closed_loop_on} = 5'h00;
    {num_errors, num_checks, warn} = 0;
    {op_mode, error_code_in, speed_measured, mode_status_bits} = 0;
    reset = 1'b1;
    void'($urandom(32'haa34));
    repeat (6) @(posedge mclk);
    reset <= 1'b0;
    // refused accesses first, then presets prove nothing changed
    for (i = 0; i < 5; i = i + 1) begin
      v = i == 0 ? `IDX_ERROR_CODE : i == 1 ? `IDX_STATE_WORD : i == 2 ? `IDX_SPEED_DEMAND
        : i == 3 ? `IDX_SPEED_ACTUAL : `IDX_BOOT_INFO;
      acc(1'b1, v, `SUB_ZERO, $urandom, 1'b1);
    end
    acc(1'b1, `IDX_SPEED_LIMITS, `SUB_ZERO, 32'h0000_0005, 1'b1);
    acc(1'b0, 16'h6045, `SUB_ZERO, 32'h0000_0000, 1'b1);
    cmp(rd, 32'h0000_0000, "unmapped");
    acc(1'b0, `IDX_COMMAND, `SUB_ONE, 32'h0000_0000, 1'b1);
    rdchk(`IDX_ERROR_CODE, `SUB_ZERO, `RST_ERROR_CODE);
    rdchk(`IDX_COMMAND, `SUB_ZERO, `RST_COMMAND);
    rdchk(`IDX_TARGET_SPEED, `SUB_ZERO, `RST_TARGET_SPEED);
    rdchk(`IDX_SPEED_DEMAND, `SUB_ZERO, `RST_SPEED);
    rdchk(`IDX_SPEED_ACTUAL, `SUB_ZERO, `RST_SPEED);
    rdchk(`IDX_SPEED_LIMITS, `SUB_ZERO, `LIMIT_ENTRIES);
    rdchk(`IDX_SPEED_LIMITS, `SUB_TWO, `RST_MAX_AMOUNT);
    rdchk(`IDX_SPEED_LIMITS, `SUB_ONE, `RST_MIN_AMOUNT);
    rdchk(`IDX_BOOT_INFO, `SUB_ZERO, `BOOT_ENTRIES);
    rdchk(`IDX_BOOT_INFO, `SUB_ONE, 32'h0005_0009);
    rdchk(`IDX_BOOT_INFO, `SUB_TWO, 32'h0000_0011);
    rdchk(`IDX_BOOT_INFO, `SUB_THREE, 32'h0000_0022);
    // power state walk, including a request in the wrong order
    step(16'h000f, `ST_INHIBIT);
    step(16'h0006, `ST_READY);
    step(16'h0007, `ST_SWITCHED_ON);
    step(16'h000f, `ST_OP_ENABLED);
    step(16'h000b, `ST_QUICK_STOP);
    // quick stop finishing, then quick stop requested from ready
    quick_stop_done <= 1'b1;
    step(16'h000b, `ST_INHIBIT);
    quick_stop_done <= 1'b0;
    step(16'h0006, `ST_READY);
    step(16'h0002, `ST_INHIBIT);
    step(16'h0006, `ST_READY);
    step(16'h0007, `ST_SWITCHED_ON);
    step(16'h000f, `ST_OP_ENABLED);
    // error, fault, blocked and successful fault clear
    v = $urandom | 16'h0001;
    @(posedge mclk);
    {error_code_in, error_event, warning_event} <= {v, 2'b11};
    @(posedge mclk);
    {error_event, warning_event} <= 2'b00;
    #1 cmp(power_state_ff, `ST_FAULT_REACT, "reaction");
    @(posedge mclk);
    {react_done, error_persists} <= 2'b11;
    @(posedge mclk);
    react_done <= 1'b0;
    #1 cmp(power_state_ff, `ST_FAULT, "fault");
    warn = 1'b1;
    rdchk(`IDX_ERROR_CODE, `SUB_ZERO, {16'h0000, v});
    step(16'h0000, `ST_FAULT);
    step(16'h0080, `ST_FAULT);
    step(16'h0000, `ST_FAULT);
    error_persists <= 1'b0;
    warn = 1'b0;
    step(16'h0080, `ST_INHIBIT);
    rdchk(`IDX_ERROR_CODE, `SUB_ZERO, 32'h0000_0000);
    // halt and mode specific bits in mode codes 0 to 7
    for (i = 0; i < 8; i = i + 1) begin
      @(posedge mclk);
      op_mode <= i;
      v = $urandom & 16'h0270 | 16'h0100;
      acc(1'b1, `IDX_COMMAND, `SUB_ZERO, {16'h0000, v}, 1'b0);
      @(posedge mclk);
      #1;
      cmp(halt_ff, i inside {1, 2, 3, 4, 7}, "halt");
      cmp(mode_specific_bits_ff, {v[9], v[6:4]}, "mode bits");
      cmp(mode_tag_ff, i, "mode tag");
    end
    // velocity mode clamping
    op_mode <= `MODE_VELOCITY;
    step(16'h0006, `ST_READY);
    step(16'h0007, `ST_SWITCHED_ON);
    step(16'h000f, `ST_OP_ENABLED);
    lo = 16'h0064;
    hi = 16'h03e8;
    acc(1'b1, `IDX_SPEED_LIMITS, `SUB_ONE, {16'h0000, lo}, 1'b0);
    acc(1'b1, `IDX_SPEED_LIMITS, `SUB_TWO, {16'h0000, hi}, 1'b0);
    for (i = 0; i < 14; i = i + 1) begin
      v = i == 0 ? hi : i == 1 ? lo : i == 2 ? -lo : i == 3 ? -hi - 1 : $urandom % 2600 - 1300;
      c = clamp(v);
      speed_measured <= $urandom;
      acc(1'b1, `IDX_TARGET_SPEED, `SUB_ZERO, {16'h0000, v}, 1'b0);
      repeat (2) @(posedge mclk);
      #1 cmp(speed_demand_ff, c[15:0], "demand");
      acc(1'b0, `IDX_STATE_WORD, `SUB_ZERO, 32'h0000_0000, 1'b0);
      cmp(rd[`SW_LIMIT], c[16], "limit flag");
      rdchk(`IDX_TARGET_SPEED, `SUB_ZERO, {16'h0000, v});
      rdchk(`IDX_SPEED_ACTUAL, `SUB_ZERO, {16'h0000, speed_measured});
    end
    acc(1'b1, `IDX_COMMAND, `SUB_ZERO, 32'h0000_010f, 1'b0);
    repeat (3) @(posedge mclk);
    #1 cmp(speed_demand_ff, 16'h0000, "halted demand");
    stop_test;
  end
endmodule // drive_state_control_status_bench
